// ### src/usbemr_pkg.sv
package usbemr_pkg;

   // endpoint count and register bus widths
   localparam int unsigned NUM_EP  = 3;
   localparam int unsigned ADDR_W  = 8;
   localparam int unsigned DATA_W  = 32;

   // register byte offsets, one aligned word each
   localparam logic [7:0] OFF_MODE0  = 8'h00;
   localparam logic [7:0] OFF_MODE1  = 8'h04;
   localparam logic [7:0] OFF_MODE2  = 8'h08;
   localparam logic [7:0] OFF_COUNT0 = 8'h0C;
   localparam logic [7:0] OFF_COUNT1 = 8'h10;
   localparam logic [7:0] OFF_COUNT2 = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;

   // field positions
   localparam int unsigned STALL_BIT     = 7;
   localparam int unsigned STAT_EP_LSB   = 4;
   localparam int unsigned STAT_TOK_LSB  = 8;

   // values after reset
   localparam logic [3:0] MODE_RESET  = 4'h0;
   localparam logic [3:0] COUNT_RESET = 4'h0;

   // endpoint mode codes
   localparam logic [3:0] M_DISABLE      = 4'h0;
   localparam logic [3:0] M_NAK_INOUT    = 4'h1;
   localparam logic [3:0] M_STATUS_OUT   = 4'h2;
   localparam logic [3:0] M_STALL_INOUT  = 4'h3;
   localparam logic [3:0] M_IGNORE_INOUT = 4'h4;
   localparam logic [3:0] M_RSV_OUT      = 4'h5;
   localparam logic [3:0] M_STATUS_IN    = 4'h6;
   localparam logic [3:0] M_RSV_IN       = 4'h7;
   localparam logic [3:0] M_NAK_OUT      = 4'h8;
   localparam logic [3:0] M_ACK_OUT      = 4'h9;
   localparam logic [3:0] M_NAKOUT_STIN  = 4'hA;
   localparam logic [3:0] M_ACKOUT_NAKIN = 4'hB;
   localparam logic [3:0] M_NAK_IN       = 4'hC;
   localparam logic [3:0] M_ACK_IN       = 4'hD;
   localparam logic [3:0] M_NAKIN_STOUT  = 4'hE;
   localparam logic [3:0] M_ACKIN_STOUT  = 4'hF;

   // token kinds from the packet decoder
   typedef enum logic [1:0] {
      TOK_SETUP = 2'b00,
      TOK_IN    = 2'b01,
      TOK_OUT   = 2'b10,
      TOK_RSV   = 2'b11
   } usbemr_tok_t;

   // answer the engine gives to a token
   typedef enum logic [2:0] {
      RESP_NONE     = 3'b000,
      RESP_ACK      = 3'b001,
      RESP_NAK      = 3'b010,
      RESP_STALL    = 3'b011,
      RESP_TX_ZERO  = 3'b100,
      RESP_TX_COUNT = 3'b101
   } usbemr_resp_t;

endpackage

// ### src/usbemr_responder.sv
// Operation
// - each endpoint keeps a four-bit mode that picks every token answer
// - mode 0000 ignores all tokens and sends no handshake
// - mode 0001 acks SETUP and naks both IN and OUT
// - control endpoint returns to 0001 after an acked SETUP, unless disabled
// - mode 1011 acks SETUP and OUT, naks IN, then goes to 0001
// - mode 0010 acks SETUP, stalls IN, checks OUT as status stage
// - mode 0011 acks SETUP and stalls both IN and OUT
// - mode 0100 acks SETUP and ignores IN and OUT
// - reserved 0101 and 0111 ignore SETUP; 0101 acks OUT, 0111 sends count
// - mode 0110 acks SETUP, sends zero-length IN, stalls OUT
// - mode 1000 ignores SETUP and IN, naks OUT
// - mode 1001 acks OUT or stalls if stall set; ack moves to 1000
// - mode 1010 acks SETUP, zero-length IN, naks OUT
// - mode 1100 ignores SETUP and OUT, naks IN
// - mode 1101 sends count or stalls on IN; host ack moves to 1100
// - mode 1110 acks SETUP, naks IN, checks OUT as status stage
// - mode 1111 acks SETUP, sends count, checks OUT; host ack goes 1110
// - data endpoints carry a stall bit at bit 7 of their mode word
// - checked OUT acks only zero-length DATA1, otherwise stall or ignore
// - a count answer sends exactly the four-bit programmed byte count
// - all modes reset to 0000 and stay until software rewrites them
// - an ignored token yields no handshake at all
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none

module usbemr_responder (
   // clock and reset
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   // apb slave
   input  wire logic [usbemr_pkg::ADDR_W-1:0] paddr,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [usbemr_pkg::DATA_W-1:0] pwdata,
   output logic      [usbemr_pkg::DATA_W-1:0] prdata,
   output logic                               pready,
   output logic                               pslverr,
   // token from the packet decoder, one-cycle pulse
   input  wire logic                          tok_valid,
   input  wire logic [1:0]                    tok_ep,
   input  wire logic [1:0]                    tok_kind,
   input  wire logic                          tok_data_ok,
   input  wire logic                          tok_zero_len,
   input  wire logic                          tok_toggle,
   // host acknowledge of in data, one-cycle pulse
   input  wire logic                          host_ack_valid,
   input  wire logic [1:0]                    host_ack_ep,
   // answer to the packet encoder
   output logic                               resp_valid,
   output logic      [2:0]                    resp_code,
   output logic      [1:0]                    resp_ep,
   output logic      [3:0]                    resp_count
);

   localparam int unsigned NEP = usbemr_pkg::NUM_EP;

   // endpoint 0 is the control endpoint
   // endpoints 1 and 2 are the data endpoints

   // a token arrives as a one-cycle pulse
   // its data-phase verdict rides along with it

   // the answer leaves one cycle after the token
   // and stands for exactly that one cycle

   // an ignored token raises no answer at all
   // so the encoder never sees a none code

   // resp_ep keeps the endpoint of the last in-range token
   // code and count fall back to zero between answers

   // mode words hold four mode bits each
   // data endpoints add the stall bit at bit 7

   // the control endpoint has no stall bit
   // its bit 7 always reads back as zero

   // count words hold a four-bit byte count
   // it is only sent out on a count answer

   // the status word is read only
   // writes to it are dropped without an error

   // status keeps the last real answer and its endpoint
   // plus a free-running token counter that wraps

   // apb access has no wait states
   // ready comes in the cycle after setup

   // read data stands in the access cycle only
   // it reads zero at every other time

   // an unmapped address raises the error flag
   // and its write is dropped

   // a write lands at the end of the access cycle
   // so a read right after sees the new word

   // hardware rewrites of a mode win over software
   // a same-cycle write to that mode is lost

   // the setup rewrite touches only endpoint 0
   // a disabled control endpoint stays disabled

   // out-ack rewrites apply on any endpoint
   // they follow our own ack, not the host's

   // in-ack rewrites wait for the host ack pulse
   // a lost host ack leaves the mode unchanged

   // bad setup data is never acked
   // the mode then stays as software left it

   // corrupted out data is ignored in every mode
   // no handshake goes back for it

   // a checked out needs empty data with toggle 1
   // anything else with good data is stalled

   // reserved codes behave as the table says
   // software should not rely on them

   // kind 3 and endpoint 3 are dropped quietly
   // kind 3 still counts in the status word; endpoint 3 does not

   // no write lock follows an ack here
   // firmware must not race the engine on a mode

   // all state sits in one packed register
   // reset clears it, so every mode starts disabled

   typedef struct packed {
      logic [NEP-1:0][3:0]            mode;
      logic [NEP-1:0]                 stall;
      logic [NEP-1:0][3:0]            count;
      logic [usbemr_pkg::DATA_W-1:0]  prdata;
      logic                           pready;
      logic                           pslverr;
      logic                           resp_valid;
      usbemr_pkg::usbemr_resp_t       resp_code;
      logic [1:0]                     resp_ep;
      logic [3:0]                     resp_count;
      usbemr_pkg::usbemr_resp_t       last_code;
      logic [1:0]                     last_ep;
      logic [7:0]                     tok_seen;
   } usbemr_state_t;

   usbemr_state_t s_q;
   usbemr_state_t s_d;

   // answer for one token from the mode and the data phase result
   function automatic usbemr_pkg::usbemr_resp_t usbemr_decide(
      input logic [3:0] mode,
      input logic       stall,
      input logic [1:0] kind,
      input logic       data_ok,
      input logic       zero_len,
      input logic       toggle
   );
      usbemr_pkg::usbemr_resp_t r;
      usbemr_pkg::usbemr_resp_t chk;
      r   = usbemr_pkg::RESP_NONE;
      // status stage check: only an empty DATA1 is accepted
      chk = (zero_len && toggle) ? usbemr_pkg::RESP_ACK
                                 : usbemr_pkg::RESP_STALL;
      case (kind)
         usbemr_pkg::TOK_SETUP: begin
            case (mode)
               usbemr_pkg::M_NAK_INOUT,
               usbemr_pkg::M_STATUS_OUT,
               usbemr_pkg::M_STALL_INOUT,
               usbemr_pkg::M_IGNORE_INOUT,
               usbemr_pkg::M_STATUS_IN,
               usbemr_pkg::M_NAKOUT_STIN,
               usbemr_pkg::M_ACKOUT_NAKIN,
               usbemr_pkg::M_NAKIN_STOUT,
               usbemr_pkg::M_ACKIN_STOUT: begin
                  // bad setup data is ignored, not acked
                  r = data_ok ? usbemr_pkg::RESP_ACK : usbemr_pkg::RESP_NONE;
               end
               default: r = usbemr_pkg::RESP_NONE;
            endcase
         end
         usbemr_pkg::TOK_IN: begin
            case (mode)
               usbemr_pkg::M_NAK_INOUT:    r = usbemr_pkg::RESP_NAK;
               usbemr_pkg::M_STATUS_OUT:   r = usbemr_pkg::RESP_STALL;
               usbemr_pkg::M_STALL_INOUT:  r = usbemr_pkg::RESP_STALL;
               usbemr_pkg::M_STATUS_IN:    r = usbemr_pkg::RESP_TX_ZERO;
               usbemr_pkg::M_RSV_IN:       r = usbemr_pkg::RESP_TX_COUNT;
               usbemr_pkg::M_NAKOUT_STIN:  r = usbemr_pkg::RESP_TX_ZERO;
               usbemr_pkg::M_ACKOUT_NAKIN: r = usbemr_pkg::RESP_NAK;
               usbemr_pkg::M_NAK_IN:       r = usbemr_pkg::RESP_NAK;
               usbemr_pkg::M_ACK_IN: begin
                  r = stall ? usbemr_pkg::RESP_STALL
                            : usbemr_pkg::RESP_TX_COUNT;
               end
               usbemr_pkg::M_NAKIN_STOUT:  r = usbemr_pkg::RESP_NAK;
               usbemr_pkg::M_ACKIN_STOUT:  r = usbemr_pkg::RESP_TX_COUNT;
               default:                    r = usbemr_pkg::RESP_NONE;
            endcase
         end
         usbemr_pkg::TOK_OUT: begin
            // corrupted out data never gets a handshake
            if (data_ok) begin
               case (mode)
                  usbemr_pkg::M_NAK_INOUT:    r = usbemr_pkg::RESP_NAK;
                  usbemr_pkg::M_STATUS_OUT:   r = chk;
                  usbemr_pkg::M_STALL_INOUT:  r = usbemr_pkg::RESP_STALL;
                  usbemr_pkg::M_RSV_OUT:      r = usbemr_pkg::RESP_ACK;
                  usbemr_pkg::M_STATUS_IN:    r = usbemr_pkg::RESP_STALL;
                  usbemr_pkg::M_NAK_OUT:      r = usbemr_pkg::RESP_NAK;
                  usbemr_pkg::M_ACK_OUT: begin
                     r = stall ? usbemr_pkg::RESP_STALL
                               : usbemr_pkg::RESP_ACK;
                  end
                  usbemr_pkg::M_NAKOUT_STIN:  r = usbemr_pkg::RESP_NAK;
                  usbemr_pkg::M_ACKOUT_NAKIN: r = usbemr_pkg::RESP_ACK;
                  usbemr_pkg::M_NAKIN_STOUT:  r = chk;
                  usbemr_pkg::M_ACKIN_STOUT:  r = chk;
                  default:                    r = usbemr_pkg::RESP_NONE;
               endcase
            end
         end
         default: r = usbemr_pkg::RESP_NONE;
      endcase
      return r;
   endfunction

   // word address decode: returns 1 when the offset is mapped
   function automatic logic usbemr_mapped(input logic [usbemr_pkg::ADDR_W-1:0] a);
      logic hit;
      case (a)
         usbemr_pkg::OFF_MODE0,
         usbemr_pkg::OFF_MODE1,
         usbemr_pkg::OFF_MODE2,
         usbemr_pkg::OFF_COUNT0,
         usbemr_pkg::OFF_COUNT1,
         usbemr_pkg::OFF_COUNT2,
         usbemr_pkg::OFF_STATUS: hit = 1'b1;
         default:                hit = 1'b0;
      endcase
      return hit;
   endfunction

   // next state: bus access first, then token effects so hardware wins
   always_comb begin
      logic                     setup_ph;
      logic                     wr_take;
      logic [usbemr_pkg::DATA_W-1:0] rd;
      logic [1:0]               ep;
      usbemr_pkg::usbemr_resp_t r;
      setup_ph = 1'b0;
      wr_take  = 1'b0;
      rd       = '0;
      ep       = 2'b00;
      r        = usbemr_pkg::RESP_NONE;
      s_d      = s_q;

      // apb: ready is set from the setup cycle and shows in the access cycle, so no wait states
      setup_ph     = psel && !penable;
      wr_take      = psel && penable && s_q.pready && pwrite;
      s_d.pready   = setup_ph;
      s_d.pslverr  = setup_ph && !usbemr_mapped(paddr);
      case (paddr)
         usbemr_pkg::OFF_MODE0:  rd[3:0] = s_q.mode[0];
         usbemr_pkg::OFF_MODE1: begin
            rd[3:0]                   = s_q.mode[1];
            rd[usbemr_pkg::STALL_BIT] = s_q.stall[1];
         end
         usbemr_pkg::OFF_MODE2: begin
            rd[3:0]                   = s_q.mode[2];
            rd[usbemr_pkg::STALL_BIT] = s_q.stall[2];
         end
         usbemr_pkg::OFF_COUNT0: rd[3:0] = s_q.count[0];
         usbemr_pkg::OFF_COUNT1: rd[3:0] = s_q.count[1];
         usbemr_pkg::OFF_COUNT2: rd[3:0] = s_q.count[2];
         usbemr_pkg::OFF_STATUS: begin
            rd[2:0]                                  = s_q.last_code;
            rd[usbemr_pkg::STAT_EP_LSB +: 2]         = s_q.last_ep;
            rd[usbemr_pkg::STAT_TOK_LSB +: 8]        = s_q.tok_seen;
         end
         default: rd = '0;
      endcase
      s_d.prdata = setup_ph ? rd : '0;

      // software writes to mode and count words
      if (wr_take) begin
         case (paddr)
            usbemr_pkg::OFF_MODE0:  s_d.mode[0] = pwdata[3:0];
            usbemr_pkg::OFF_MODE1: begin
               s_d.mode[1]  = pwdata[3:0];
               s_d.stall[1] = pwdata[usbemr_pkg::STALL_BIT];
            end
            usbemr_pkg::OFF_MODE2: begin
               s_d.mode[2]  = pwdata[3:0];
               s_d.stall[2] = pwdata[usbemr_pkg::STALL_BIT];
            end
            usbemr_pkg::OFF_COUNT0: s_d.count[0] = pwdata[3:0];
            usbemr_pkg::OFF_COUNT1: s_d.count[1] = pwdata[3:0];
            usbemr_pkg::OFF_COUNT2: s_d.count[2] = pwdata[3:0];
            default: s_d.mode = s_d.mode;
         endcase
      end

      // token answer; an out-of-range endpoint gets nothing
      s_d.resp_valid = 1'b0;
      s_d.resp_code  = usbemr_pkg::RESP_NONE;
      s_d.resp_count = 4'h0;
      ep             = tok_ep;
      if (tok_valid && (ep < 2'(NEP))) begin
         r = usbemr_decide(s_q.mode[ep], (ep != 2'b00) && s_q.stall[ep],
                           tok_kind, tok_data_ok, tok_zero_len, tok_toggle);
         s_d.resp_valid = (r != usbemr_pkg::RESP_NONE);
         s_d.resp_code  = r;
         s_d.resp_ep    = ep;
         s_d.resp_count = (r == usbemr_pkg::RESP_TX_COUNT) ? s_q.count[ep]
                                                           : 4'h0;
         s_d.tok_seen   = s_q.tok_seen + 8'h01;
         if (r != usbemr_pkg::RESP_NONE) begin
            s_d.last_code = r;
            s_d.last_ep   = ep;
         end
         // rewrites follow only our own ack; they override a same-cycle write
         if (r == usbemr_pkg::RESP_ACK) begin
            if (tok_kind == usbemr_pkg::TOK_SETUP && ep == 2'b00 &&
                s_q.mode[0] != usbemr_pkg::M_DISABLE) begin
               s_d.mode[0] = usbemr_pkg::M_NAK_INOUT;
            end
            if (tok_kind == usbemr_pkg::TOK_OUT) begin
               if (s_q.mode[ep] == usbemr_pkg::M_ACKOUT_NAKIN) begin
                  s_d.mode[ep] = usbemr_pkg::M_NAK_INOUT;
               end
               if (s_q.mode[ep] == usbemr_pkg::M_ACK_OUT) begin
                  s_d.mode[ep] = usbemr_pkg::M_NAK_OUT;
               end
            end
         end
      end

      // host acknowledged our in data: leave the ack-in modes
      if (host_ack_valid && (host_ack_ep < 2'(NEP))) begin
         if (s_q.mode[host_ack_ep] == usbemr_pkg::M_ACK_IN) begin
            s_d.mode[host_ack_ep] = usbemr_pkg::M_NAK_IN;
         end
         if (s_q.mode[host_ack_ep] == usbemr_pkg::M_ACKIN_STOUT) begin
            s_d.mode[host_ack_ep] = usbemr_pkg::M_NAKIN_STOUT;
         end
      end
      // control endpoint has no stall bit
      s_d.stall[0] = 1'b0;
   end

   // all state in one register; reset leaves every endpoint disabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state register
   assign prdata     = s_q.prdata;
   assign pready     = s_q.pready;
   assign pslverr    = s_q.pslverr;
   assign resp_valid = s_q.resp_valid;
   assign resp_code  = s_q.resp_code;
   assign resp_ep    = s_q.resp_ep;
   assign resp_count = s_q.resp_count;

endmodule

`default_nettype wire

// ### bench/usbemr_monitor.sv
`timescale 1ns/1ns
`default_nettype none

module usbemr_monitor (
   // clock and reset
   input wire logic       pclk,
   input wire logic       presetn,
   // token side
   input wire logic       tok_valid,
   input wire logic [1:0] tok_ep,
   input wire logic [1:0] tok_kind,
   input wire logic       tok_data_ok,
   // answer side
   input wire logic       resp_valid,
   input wire logic [2:0] resp_code,
   input wire logic [1:0] resp_ep,
   input wire logic [3:0] resp_count
);
   // one domain, so clock and reset are given once
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // no token, no answer the next cycle
   property p_quiet;
      !tok_valid |=> !resp_valid;
   endproperty
   a_quiet: assert property (p_quiet) else $error("answer without a token");

   property p_ep3;
      tok_valid && tok_ep == 2'h3 |=> !resp_valid;
   endproperty
   a_ep3: assert property (p_ep3) else $error("answer to an unknown endpoint");

   // a broken setup data phase is ignored
   property p_bad_setup;
      tok_valid && tok_kind == 2'h0 && !tok_data_ok |=> !resp_valid;
   endproperty
   a_bad_setup: assert property (p_bad_setup) else $error("answer to bad setup");

   property p_bad_out;
      tok_valid && tok_kind == 2'h2 && !tok_data_ok |=> !resp_valid;
   endproperty
   a_bad_out: assert property (p_bad_out) else $error("answer to bad out data");

   // count is only carried by a count answer
   property p_count;
      resp_valid && resp_code != usbemr_pkg::RESP_TX_COUNT |-> resp_count == 4'h0;
   endproperty
   a_count: assert property (p_count) else $error("count on a non-count answer");

   // data packets only ever answer in tokens
   property p_data_in;
      resp_valid && resp_code inside {usbemr_pkg::RESP_TX_ZERO, usbemr_pkg::RESP_TX_COUNT}
         |-> $past(tok_kind) == usbemr_pkg::TOK_IN;
   endproperty
   a_data_in: assert property (p_data_in) else $error("data sent to a non-in token");

   property p_ack_kind;
      resp_valid && resp_code == usbemr_pkg::RESP_ACK |-> $past(tok_kind) != usbemr_pkg::TOK_IN;
   endproperty
   a_ack_kind: assert property (p_ack_kind) else $error("ack given to an in token");

   property p_resp_ep;
      resp_valid |-> $past(tok_valid) && resp_ep == $past(tok_ep);
   endproperty
   a_resp_ep: assert property (p_resp_ep) else $error("answer on wrong endpoint");
endmodule

bind usbemr_responder usbemr_monitor u_mon (
   .pclk        (pclk),
   .presetn     (presetn),
   .tok_valid   (tok_valid),
   .tok_ep      (tok_ep),
   .tok_kind    (tok_kind),
   .tok_data_ok (tok_data_ok),
   .resp_valid  (resp_valid),
   .resp_code   (resp_code),
   .resp_ep     (resp_ep),
   .resp_count  (resp_count)
);

`default_nettype wire

// ### bench/usbemr_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module usbemr_host_model (
   // clock
   input  wire logic       pclk,
   // token lines
   output logic            tok_valid,
   output logic      [1:0] tok_ep,
   output logic      [1:0] tok_kind,
   output logic      [2:0] tok_flags,
   // host acknowledge
   output logic            host_ack_valid,
   output logic      [1:0] host_ack_ep
);
   initial begin
      tok_valid = 1'b0;
      tok_ep = 2'h0;
      tok_kind = 2'h0;
      tok_flags = 3'h0;
      host_ack_valid = 1'b0;
      host_ack_ep = 2'h0;
   end

   // flags are data ok, zero length, toggle; lines invert when idle so stale values never match
   task automatic send(input logic [1:0] ep, input logic [1:0] kind, input logic [2:0] f);
      @(posedge pclk);
      tok_valid <= 1'b1;
      tok_ep <= ep;
      tok_kind <= kind;
      tok_flags <= f;
      @(posedge pclk);
      tok_valid <= 1'b0;
      tok_ep <= ~ep;
      tok_kind <= ~kind;
      tok_flags <= ~f;
   endtask

   // host accepts the in data just sent
   task automatic ack(input logic [1:0] ep);
      @(posedge pclk);
      host_ack_valid <= 1'b1;
      host_ack_ep <= ep;
      @(posedge pclk);
      host_ack_valid <= 1'b0;
      host_ack_ep <= ~ep;
   endtask
endmodule

`default_nettype wire

// ### bench/test_usb_endpoint_mode_responder.sv
`timescale 1ns/1ns
`default_nettype none

module test_usb_endpoint_mode_responder;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        tok_valid, host_ack_valid, resp_valid;
   logic [1:0]  tok_ep, tok_kind, host_ack_ep, resp_ep;
   logic [2:0]  tok_flags, resp_code;
   logic [3:0]  resp_count;
   logic [3:0]  cnt [3] = '{4'h3, 4'h5, 4'hF};
   int          num_errors = 0;
   int          compares = 0;
   // short aliases keep the table readable
   localparam logic [1:0] SU = usbemr_pkg::TOK_SETUP, IN = usbemr_pkg::TOK_IN;
   localparam logic [1:0] OT = usbemr_pkg::TOK_OUT;
   localparam logic [2:0] RN = usbemr_pkg::RESP_NONE, RA = usbemr_pkg::RESP_ACK;
   localparam logic [2:0] RK = usbemr_pkg::RESP_NAK, RS = usbemr_pkg::RESP_STALL;
   localparam logic [2:0] RZ = usbemr_pkg::RESP_TX_ZERO, RC = usbemr_pkg::RESP_TX_COUNT;

   usbemr_responder DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tok_valid(tok_valid), .tok_ep(tok_ep),
      .tok_kind(tok_kind), .tok_data_ok(tok_flags[2]), .tok_zero_len(tok_flags[1]),
      .tok_toggle(tok_flags[0]), .host_ack_valid(host_ack_valid),
      .host_ack_ep(host_ack_ep), .resp_valid(resp_valid), .resp_code(resp_code),
      .resp_ep(resp_ep), .resp_count(resp_count));

   usbemr_host_model HOST (.pclk(pclk), .tok_valid(tok_valid), .tok_ep(tok_ep),
      .tok_kind(tok_kind), .tok_flags(tok_flags), .host_ack_valid(host_ack_valid),
      .host_ack_ep(host_ack_ep));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // set a mode, send one token, check the answer and the mode left behind
   task automatic run(input logic [1:0] ep, input logic [7:0] m, input logic [1:0] k,
                      input logic [2:0] f, input logic ack, input logic [2:0] exp,
                      input logic [7:0] nm);
      apb(1'b1, {4'h0, ep, 2'h0}, {24'h0, m});
      HOST.send(ep, k, f);
      @(posedge pclk);
      chk("resp_valid", {31'h0, exp != RN}, {31'h0, resp_valid});
      if (exp != RN) begin
         chk("resp_code", {29'h0, exp}, {29'h0, resp_code});
         chk("resp_ep", {30'h0, ep}, {30'h0, resp_ep});
         chk("resp_count", (exp == RC) ? {28'h0, cnt[ep]} : 32'h0, {28'h0, resp_count});
      end
      if (ack) HOST.ack(ep);
      apb(1'b0, {4'h0, ep, 2'h0}, 32'h0);
      chk("mode", {24'h0, nm}, rd);
   endtask

   task automatic close_out();
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // a hung handshake ends the run as a failure
   initial begin
      #500000;
      num_errors++;
      close_out();
   end

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      for (int e = 0; e < 3; e++) begin
         apb(1'b0, {e[5:0], 2'h0}, 32'h0);
         chk("mode after reset", 32'h0, rd);
      end
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      apb(1'b1, usbemr_pkg::OFF_COUNT0, 32'h3);
      apb(1'b1, usbemr_pkg::OFF_COUNT1, 32'h5);
      apb(1'b1, usbemr_pkg::OFF_COUNT2, 32'hF);
      run(2'h1, 8'h00, IN, 3'h4, 1'b0, RN, 8'h00);
      run(2'h0, 8'h00, SU, 3'h4, 1'b0, RN, 8'h00);
      run(2'h0, 8'h01, SU, 3'h4, 1'b0, RA, 8'h01);
      run(2'h0, 8'h01, SU, 3'h0, 1'b0, RN, 8'h01);
      run(2'h0, 8'h01, IN, 3'h4, 1'b0, RK, 8'h01);
      run(2'h0, 8'h01, OT, 3'h4, 1'b0, RK, 8'h01);
      run(2'h0, 8'h01, 2'h3, 3'h4, 1'b0, RN, 8'h01);
      run(2'h0, 8'h02, SU, 3'h4, 1'b0, RA, 8'h01);
      run(2'h0, 8'h02, IN, 3'h4, 1'b0, RS, 8'h02);
      run(2'h0, 8'h02, OT, 3'h7, 1'b0, RA, 8'h02);
      run(2'h0, 8'h02, OT, 3'h6, 1'b0, RS, 8'h02);
      run(2'h0, 8'h0E, OT, 3'h3, 1'b0, RN, 8'h0E);
      run(2'h0, 8'h83, IN, 3'h4, 1'b0, RS, 8'h03);
      run(2'h0, 8'h03, OT, 3'h4, 1'b0, RS, 8'h03);
      run(2'h0, 8'h04, SU, 3'h4, 1'b0, RA, 8'h01);
      run(2'h0, 8'h04, IN, 3'h4, 1'b0, RN, 8'h04);
      run(2'h0, 8'h04, OT, 3'h4, 1'b0, RN, 8'h04);
      run(2'h1, 8'h05, SU, 3'h4, 1'b0, RN, 8'h05);
      run(2'h1, 8'h05, OT, 3'h4, 1'b0, RA, 8'h05);
      run(2'h2, 8'h07, IN, 3'h4, 1'b0, RC, 8'h07);
      run(2'h2, 8'h07, OT, 3'h4, 1'b0, RN, 8'h07);
      run(2'h0, 8'h06, IN, 3'h4, 1'b0, RZ, 8'h06);
      run(2'h0, 8'h06, OT, 3'h4, 1'b0, RS, 8'h06);
      run(2'h1, 8'h08, SU, 3'h4, 1'b0, RN, 8'h08);
      run(2'h1, 8'h08, OT, 3'h4, 1'b0, RK, 8'h08);
      run(2'h1, 8'h09, OT, 3'h4, 1'b0, RA, 8'h08);
      run(2'h1, 8'h89, OT, 3'h4, 1'b0, RS, 8'h89);
      run(2'h0, 8'h0A, IN, 3'h4, 1'b0, RZ, 8'h0A);
      run(2'h0, 8'h0A, OT, 3'h4, 1'b0, RK, 8'h0A);
      run(2'h0, 8'h0B, IN, 3'h4, 1'b0, RK, 8'h0B);
      run(2'h0, 8'h0B, OT, 3'h4, 1'b0, RA, 8'h01);
      run(2'h2, 8'h0C, IN, 3'h4, 1'b0, RK, 8'h0C);
      run(2'h2, 8'h0C, OT, 3'h4, 1'b0, RN, 8'h0C);
      run(2'h1, 8'h0D, IN, 3'h4, 1'b0, RC, 8'h0D);
      run(2'h1, 8'h0D, IN, 3'h4, 1'b1, RC, 8'h0C);
      run(2'h2, 8'h8D, IN, 3'h4, 1'b0, RS, 8'h8D);
      run(2'h0, 8'h0E, IN, 3'h4, 1'b0, RK, 8'h0E);
      run(2'h0, 8'h0E, OT, 3'h7, 1'b0, RA, 8'h0E);
      run(2'h0, 8'h0F, IN, 3'h4, 1'b1, RC, 8'h0E);
      run(2'h0, 8'h0F, SU, 3'h4, 1'b0, RA, 8'h01);
      HOST.send(2'h3, IN, 3'h4);
      @(posedge pclk);
      chk("resp_valid ep3", 32'h0, {31'h0, resp_valid});
      apb(1'b0, usbemr_pkg::OFF_STATUS, 32'h0);
      chk("status last answer", 32'h01, rd & 32'h3F);
      close_out();
   end
endmodule

`default_nettype wire
